/* dv/tbgp_pin_model.sv */
/*
  Far-side pin model: resolves two pins from drive and enable.
  Assumes one outside driver per pin, always active.
*/
module tbgp_pin_model (
  input  wire logic [1:0] pin_out,
  input  wire logic [1:0] pin_oe,
  input  wire logic [1:0] ext_val,
  output logic [1:0]      pin_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  // device drive wins, no contention modelled
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule // tbgp_pin_model

/* dv/tbgp_ports_test.sv */
/*
  Self-checking bench for tbgp_ports.
  Assumes zero-wait APB answers bounded by a timeout.
*/
module tbgp_ports_test;
  import tbgp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'h0, rst = 1'h1, ce = 1'h1, sen = 1'h0, stx = 1'h0;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        pready, pslverr, srx;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0]  pstrb = 4'h0, els = 4'h0;
  logic [1:0]  d_out, d_oe, d_pin, e_out, e_oe, e_pin, tpin;
  logic [1:0]  d_ext = 2'h0, e_ext = 2'h0, cmode = 2'h0, cout = 2'h0;
  int          err_count = 0, num_checks = 0;
  localparam logic [7:0] DD = TBGP_PORT_D_PIN_DATA_IDX;
  localparam logic [7:0] ED = TBGP_PORT_E_PIN_DATA_IDX;
  localparam logic [7:0] DR = TBGP_PORT_D_DIRECTION_IDX;
  localparam logic [7:0] ER = TBGP_PORT_E_DIRECTION_IDX;

  tbgp_ports dut_u (.mclk, .rst, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .first_port_pin_in(d_pin), .first_port_pin_out(d_out),
    .first_port_pin_oe(d_oe), .second_port_pin_in(e_pin),
    .second_port_pin_out(e_out), .second_port_pin_oe(e_oe),
    .timer_edge_level_select(els), .timer_compare_mode(cmode),
    .timer_compare_out(cout), .timer_channel_pin(tpin),
    .serial_interface_enable(sen), .serial_transmit_data(stx),
    .serial_receive_data(srx));
  tbgp_pin_model pm_d (.pin_out(d_out), .pin_oe(d_oe), .ext_val(d_ext),
    .pin_lvl(d_pin));
  tbgp_pin_model pm_e (.pin_out(e_out), .pin_oe(e_oe), .ext_val(e_ext),
    .pin_lvl(e_pin));

  always #2.5 mclk = ~mclk;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task check(input logic [31:0] seen, exp, input string m);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s: got %h want %h", $time, m, seen, exp);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task apb(input logic w, input logic [7:0] i, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge mclk);
    penable <= 1'h1;
    // only the watchdog ends a wait that never completes
    do begin
      @(posedge mclk);
    end while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task wr(input logic [7:0] i, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'h1, i, d, r, e);
  endtask
  task rdc(input logic [7:0] i, input logic [31:0] x, input string m);
    logic [31:0] r;
    logic        e;
    apb(1'h0, i, 32'h0, r, e);
    check(r, x, m);
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task t_reset;
    rdc(DR, 32'h0, "d dir reset");
    rdc(ER, 32'h0, "e dir reset");
  endtask
  task t_gpio(input logic [7:0] di, ri, input logic e);
    if (e) e_ext <= 2'h2;
    else d_ext <= 2'h2;
    wr(di, 32'h1);
    wt(6);
    rdc(di, 32'h2, "input reads pin");
    check(e ? e_oe : d_oe, 32'h0, "input not driven");
    // latch loaded before turning on the drive
    wr(ri, 32'h3);
    wt(2);
    check(e ? e_pin : d_pin, 32'h1, "drives latch");
    rdc(di, 32'h1, "output reads latch");
    wr(ri, 32'h1);
    wt(6);
    rdc(di, 32'h3, "mixed read");
    wr(ri, 32'hffff_fffc);
    rdc(ri, 32'h0, "upper bits ignored");
  endtask
  task t_latch_rst;
    wr(ED, 32'h2);
    rst <= 1'h1;
    wt(2);
    rst <= 1'h0;
    rdc(DR, 32'h0, "d dir cleared");
    rdc(ER, 32'h0, "e dir cleared");
    wr(ER, 32'h3);
    rdc(ED, 32'h2, "latch kept");
    wr(ER, 32'h0);
  endtask
  task t_serial;
    wr(ED, 32'h0);
    sen <= 1'h1;
    wt(6);
    check(e_oe, 32'h1, "serial owns pins");
    check(srx, 32'h1, "receive level");
    rdc(ED, 32'h2, "pins read");
    stx <= 1'h1;
    wr(ER, 32'h3);
    wt(2);
    check({e_oe, e_pin[0]}, 32'h3, "dir ignored");
    rdc(ED, 32'h0, "latch read");
    sen <= 1'h0;
    wt(2);
    check(e_oe, 32'h3, "gpio again");
    wr(ER, 32'h0);
  endtask
  task t_timer;
    d_ext <= 2'h2;
    wr(DD, 32'h0);
    wr(DR, 32'h3);
    els <= 4'h9;
    cmode <= 2'h1;
    cout <= 2'h1;
    wt(6);
    check({d_oe, d_pin, tpin}, 32'h1f, "timer owns pins");
    rdc(DD, 32'h0, "dir picks latch");
    wr(DR, 32'h0);
    wt(6);
    rdc(DD, 32'h3, "dir picks pin");
    els <= 4'h0;
    wt(2);
    check(d_oe, 32'h0, "gpio again");
  endtask
  task t_bus;
    logic [31:0] r;
    logic        e;
    apb(1'h0, 8'h01, 32'h0, r, e);
    check({e, r[30:0]}, 32'h8000_0000, "unmapped");
  endtask

  task give_verdict;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    wt(12);
    rst <= 1'h0;
    t_reset;
    t_gpio(DD, DR, 1'h0);
    t_gpio(ED, ER, 1'h1);
    t_latch_rst;
    t_serial;
    t_timer;
    t_bus;
    give_verdict;
  end
  // the tests need well under a thousand cycles
  initial begin
    #20000;
    err_count++;
    give_verdict;
  end
endmodule // tbgp_ports_test

/* dv/tbgp_props.sv */
/*
  Checker for tbgp_ports, bound to its ports.
  Assumes mclk and a synchronous active-high rst.
*/
module tbgp_props
  import tbgp_pkg::*;
#(
  parameter int unsigned PINS = TBGP_PORT_PINS
)
(
  input wire logic                       mclk,
  input wire logic                       rst,
  input wire logic                       ce,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [TBGP_ADDR_WIDTH-1:0] paddr,
  input wire logic [TBGP_DATA_WIDTH-1:0] pwdata,
  input wire logic [3:0]                 pstrb,
  input wire logic [TBGP_DATA_WIDTH-1:0] prdata,
  input wire logic [PINS-1:0]            first_port_pin_out,
  input wire logic [PINS-1:0]            first_port_pin_oe,
  input wire logic [PINS-1:0]            second_port_pin_out,
  input wire logic [PINS-1:0]            second_port_pin_oe,
  input wire logic [2*PINS-1:0]          timer_edge_level_select,
  input wire logic [PINS-1:0]            timer_compare_mode,
  input wire logic [PINS-1:0]            timer_compare_out,
  input wire logic                       serial_interface_enable,
  input wire logic                       serial_transmit_data
);
  // ----------------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------------
  logic            wr_go;
  logic            wr_d;
  logic            wr_e;
  logic [PINS-1:0] wdat;
  assign wr_go = psel && penable && pwrite && ce && pstrb[0];
  assign wr_d  = wr_go && paddr == {2'h0, TBGP_PORT_D_DIRECTION_IDX, 2'h0};
  assign wr_e  = wr_go && paddr == {2'h0, TBGP_PORT_E_DIRECTION_IDX, 2'h0};
  assign wdat  = pwdata[PINS-1:0];

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  // pin enable lags the register by one edge
  // take-over must stay off until the enable edge, or the timer owns it
  a_first_dir_oe: assert property (
    wr_d && timer_edge_level_select == '0
    ##1 timer_edge_level_select == '0
    |=> first_port_pin_oe == $past(wdat, 2))
    else $error("first port enable not from direction");
  a_second_dir_oe: assert property (
    wr_e && !serial_interface_enable
    ##1 !serial_interface_enable
    |=> second_port_pin_oe == $past(wdat, 2))
    else $error("second port enable not from direction");
  a_reset_oe_low: assert property (
    $fell(rst) |-> first_port_pin_oe == '0 && second_port_pin_oe == '0)
    else $error("pin driven after reset");
  a_upper_read_zero: assert property (
    psel && penable |-> prdata[TBGP_DATA_WIDTH-1:PINS] == '0)
    else $error("upper read bits not zero");
  a_serial_tx_drive: assert property (
    serial_interface_enable |=> second_port_pin_oe[0]
    && second_port_pin_out[0] == $past(serial_transmit_data))
    else $error("transmit pin not driven by serial unit");
  a_serial_rx_free: assert property (
    serial_interface_enable |=> !second_port_pin_oe[1])
    else $error("receive pin driven");
  a_timer_compare: assert property (
    timer_edge_level_select[1:0] != '0 && timer_compare_mode[0]
    |=> first_port_pin_oe[0]
    && first_port_pin_out[0] == $past(timer_compare_out[0]))
    else $error("compare channel not driving pin");
  a_timer_capture: assert property (
    timer_edge_level_select[3:2] != '0 && !timer_compare_mode[1]
    |=> !first_port_pin_oe[1])
    else $error("capture channel pin driven");

  c_dir_write: cover property (wr_d);
  c_serial_on: cover property (serial_interface_enable);
  c_read: cover property (psel && penable && !pwrite);
endmodule // tbgp_props

bind tbgp_ports tbgp_props #(.PINS(PINS)) props_u (
  .mclk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .prdata, .first_port_pin_out, .first_port_pin_oe, .second_port_pin_out,
  .second_port_pin_oe, .timer_edge_level_select, .timer_compare_mode,
  .timer_compare_out, .serial_interface_enable, .serial_transmit_data
);

/* rtl/tbgp_pin_cell.sv */
/*
  Combinational steering for one shared port pin: drive, enable and the
  value a data read returns.
  Assumes the alternate unit's take-over, drive and enable come from
  logic on mclk.
*/
module tbgp_pin_cell
  import tbgp_pkg::*;
(
  input  wire logic direction_bit,
  input  wire logic latch_bit,
  input  wire logic alt_active,
  input  wire logic alt_out,
  input  wire logic alt_oe,
  input  wire logic pin_level,
  output logic      next_pin_out,
  output logic      next_pin_oe,
  output logic      read_bit
);

  // ----------------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------------
  always_comb begin
    if (alt_active) begin
      next_pin_out = alt_out;
      next_pin_oe  = alt_oe;
    end else begin
      next_pin_out = latch_bit;
      next_pin_oe  = direction_bit;
    end
  end

  // ----------------------------------------------------------------------
  // read-back
  // ----------------------------------------------------------------------
  // direction keeps choosing latch or pin even under take-over
  always_comb begin
    read_bit = direction_bit ? latch_bit : pin_level;
  end

endmodule // tbgp_pin_cell

/* rtl/tbgp_pin_sync.sv */
/*
  Three-stage synchroniser with agreement filter for one pin level.
  Assumes the pin is asynchronous to mclk; output lags the pin by three
  to four enabled clocks.
*/
module tbgp_pin_sync
  import tbgp_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic pin_async,
  output logic      pin_level
);

  logic stage1;
  logic stage2;
  logic stage3;

  // ----------------------------------------------------------------------
  // stages
  // ----------------------------------------------------------------------
  // stage1 feeds only stage2, so no gate sees a metastable value
  always_ff @(posedge mclk) begin
    if (rst) begin
      stage1 <= TBGP_SYNC_RESET;
      stage2 <= TBGP_SYNC_RESET;
      stage3 <= TBGP_SYNC_RESET;
    end else if (ce) begin
      stage1 <= pin_async;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a change counts only once the second and third stages agree
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_level <= TBGP_SYNC_RESET;
    end else if (ce && (stage2 == stage3)) begin
      pin_level <= stage3;
    end
  end

endmodule // tbgp_pin_sync

/* rtl/tbgp_pkg.sv */
/*
  Holds the register map, field layout and reset values of the two-pin
  general-purpose ports.
  Assumes a 32-bit APB master that uses byte addresses four times the
  register index.
*/
package tbgp_pkg;

  // ----------------------------------------------------------------------
  // register indexes (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [7:0] TBGP_PORT_D_PIN_DATA_IDX  = 8'h03;
  localparam logic [7:0] TBGP_PORT_E_PIN_DATA_IDX  = 8'h08;
  localparam logic [7:0] TBGP_PORT_D_DIRECTION_IDX = 8'h07;
  localparam logic [7:0] TBGP_PORT_E_DIRECTION_IDX = 8'h0c;

  localparam int unsigned TBGP_ADDR_WIDTH  = 12;
  localparam int unsigned TBGP_INDEX_SHIFT = 2;

  // ----------------------------------------------------------------------
  // field layout and widths
  // ----------------------------------------------------------------------
  localparam int unsigned TBGP_PORT_PINS   = 2;
  localparam int unsigned TBGP_REG_WIDTH   = 8;
  localparam int unsigned TBGP_DATA_WIDTH  = 32;
  localparam int unsigned TBGP_RECEIVE_BIT = 1;
  localparam int unsigned TBGP_TRANSMIT_BIT = 0;
  localparam int unsigned TBGP_ELS_WIDTH   = 2;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0]  TBGP_DIRECTION_RESET = 2'h0;
  localparam logic [1:0]  TBGP_PIN_OUT_RESET   = 2'h0;
  localparam logic [31:0] TBGP_READ_ZERO       = 32'h0000_0000;
  localparam logic [1:0]  TBGP_ELS_DISABLED    = 2'h0;
  localparam logic        TBGP_SYNC_RESET      = 1'b0;

  typedef enum logic [1:0] {
    TBGP_REG_PORT_D_DATA,
    TBGP_REG_PORT_E_DATA,
    TBGP_REG_PORT_D_DIR,
    TBGP_REG_PORT_E_DIR
  } tbgp_reg_type;

endpackage

/* rtl/tbgp_ports.sv */
/*
  Two two-pin general-purpose ports behind an APB slave. The first port
  is shared with two timer channels, the second with the serial unit's
  receive and transmit lines.
  Assumes an APB master on mclk, a timer and a serial unit on mclk that
  supply take-over and drive signals, and pad logic that resolves each
  pin from its output and enable.
*/
// Design decision made here: the APB interface to the registers.
// Functional notes
// - first port direction one drives the pin, zero makes it input.
// - reset clears both first port direction bits, all pins inputs.
// - first port read gives latch if direction one, pin level otherwise.
// - data writes with pstrb[0] set update the latches, whatever the direction.
// - writing an input pin's latch changes neither pin nor read value.
// - second port direction one drives the pin, zero makes it input.
// - reset clears both second port direction bits, all pins inputs.
// - reset leaves the second port data latches unchanged.
// - second port read gives latch if direction one, pin otherwise.
// - second port bit 1 is serial receive input while serial enabled.
// - second port bit 0 drives serial transmit while serial enabled.
// - under serial use direction only steers read-back, not the pin.
// - under timer use direction only steers read-back, not the pin.
// - timer edge/level select takes first port pins as channels.
module tbgp_ports
  import tbgp_pkg::*;
#(
  parameter int unsigned PINS = TBGP_PORT_PINS
)
(
  input  wire logic                       mclk,
  input  wire logic                       rst,
  input  wire logic                       ce,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [TBGP_ADDR_WIDTH-1:0] paddr,
  input  wire logic [TBGP_DATA_WIDTH-1:0] pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic [TBGP_DATA_WIDTH-1:0]      prdata,
  output logic                            pready,
  output logic                            pslverr,
  // first port pins
  input  wire logic [PINS-1:0]            first_port_pin_in,
  output logic [PINS-1:0]                 first_port_pin_out,
  output logic [PINS-1:0]                 first_port_pin_oe,
  // second port pins
  input  wire logic [PINS-1:0]            second_port_pin_in,
  output logic [PINS-1:0]                 second_port_pin_out,
  output logic [PINS-1:0]                 second_port_pin_oe,
  // first timer unit
  input  wire logic [2*PINS-1:0]          timer_edge_level_select,
  input  wire logic [PINS-1:0]            timer_compare_mode,
  input  wire logic [PINS-1:0]            timer_compare_out,
  output logic [PINS-1:0]                 timer_channel_pin,
  // async serial unit
  input  wire logic                       serial_interface_enable,
  input  wire logic                       serial_transmit_data,
  output logic                            serial_receive_data
);

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic [PINS-1:0] first_port_latch;
  logic [PINS-1:0] second_port_latch;
  logic [PINS-1:0] first_port_direction;
  logic [PINS-1:0] second_port_direction;

  logic [PINS-1:0] first_pin_level;
  logic [PINS-1:0] second_pin_level;

  logic [PINS-1:0] first_alt_active;
  logic [PINS-1:0] first_alt_out;
  logic [PINS-1:0] first_alt_oe;
  logic [PINS-1:0] second_alt_active;
  logic [PINS-1:0] second_alt_out;
  logic [PINS-1:0] second_alt_oe;

  logic [PINS-1:0] next_first_pin_out;
  logic [PINS-1:0] next_first_pin_oe;
  logic [PINS-1:0] next_second_pin_out;
  logic [PINS-1:0] next_second_pin_oe;
  logic [PINS-1:0] first_read;
  logic [PINS-1:0] second_read;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  logic [7:0]                 bus_index;
  logic                       bus_aligned;
  logic                       bus_setup;
  logic                       bus_write;
  logic                       bus_lane0;
  logic                       hit_first_data;
  logic                       hit_second_data;
  logic                       hit_first_dir;
  logic                       hit_second_dir;
  logic                       hit_any;
  logic [TBGP_DATA_WIDTH-1:0] next_prdata;
  logic                       next_pslverr;
  logic                       err_flag;
  logic [PINS-1:0]            write_bits;

  assign bus_index = paddr[TBGP_INDEX_SHIFT+7:TBGP_INDEX_SHIFT];
  assign bus_aligned = (paddr[TBGP_INDEX_SHIFT-1:0] == '0) &&
                       (paddr[TBGP_ADDR_WIDTH-1:TBGP_INDEX_SHIFT+8] == '0);
  assign bus_setup = psel && !penable && ce;
  assign hit_first_data  = bus_aligned &&
                           (bus_index == TBGP_PORT_D_PIN_DATA_IDX);
  assign hit_second_data = bus_aligned &&
                           (bus_index == TBGP_PORT_E_PIN_DATA_IDX);
  assign hit_first_dir   = bus_aligned &&
                           (bus_index == TBGP_PORT_D_DIRECTION_IDX);
  assign hit_second_dir  = bus_aligned &&
                           (bus_index == TBGP_PORT_E_DIRECTION_IDX);
  assign hit_any = hit_first_data || hit_second_data ||
                   hit_first_dir || hit_second_dir;

  // no wait states; the access phase completes on its first enabled edge
  assign pready = ce;

  // write commits only at the completing edge of the access phase
  assign bus_write = psel && penable && pwrite && ce;
  assign bus_lane0 = pstrb[0];
  assign write_bits = pwdata[PINS-1:0];

  // ----------------------------------------------------------------------
  // read data, captured in the setup cycle
  // ----------------------------------------------------------------------
  // upper bits stay zero for every location
  always_comb begin
    next_prdata  = TBGP_READ_ZERO;
    next_pslverr = !hit_any;
    if (!pwrite) begin
      if (hit_first_data) begin
        next_prdata[PINS-1:0] = first_read;
      end else if (hit_second_data) begin
        next_prdata[PINS-1:0] = second_read;
      end else if (hit_first_dir) begin
        next_prdata[PINS-1:0] = first_port_direction;
      end else if (hit_second_dir) begin
        next_prdata[PINS-1:0] = second_port_direction;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata <= TBGP_READ_ZERO;
    end else if (bus_setup) begin
      prdata <= next_prdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      err_flag <= 1'b0;
    end else if (bus_setup) begin
      err_flag <= next_pslverr;
    end
  end

  assign pslverr = err_flag && psel && penable;

  // ----------------------------------------------------------------------
  // data latches
  // ----------------------------------------------------------------------
  // no reset term: a port reset must not disturb the latched levels
  always_ff @(posedge mclk) begin
    if (bus_write && bus_lane0 && hit_first_data) begin
      first_port_latch <= write_bits;
    end
  end

  always_ff @(posedge mclk) begin
    if (bus_write && bus_lane0 && hit_second_data) begin
      second_port_latch <= write_bits;
    end
  end

  // ----------------------------------------------------------------------
  // direction registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      first_port_direction <= TBGP_DIRECTION_RESET;
    end else if (bus_write && bus_lane0 && hit_first_dir) begin
      first_port_direction <= write_bits;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      second_port_direction <= TBGP_DIRECTION_RESET;
    end else if (bus_write && bus_lane0 && hit_second_dir) begin
      second_port_direction <= write_bits;
    end
  end

  // ----------------------------------------------------------------------
  // alternate functions
  // ----------------------------------------------------------------------
  // any non-zero edge/level select hands the pin to the timer
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      first_alt_active[i] =
        timer_edge_level_select[i*TBGP_ELS_WIDTH +: TBGP_ELS_WIDTH] !=
        TBGP_ELS_DISABLED;
      first_alt_out[i] = timer_compare_out[i];
      first_alt_oe[i]  = timer_compare_mode[i];
    end
  end

  // receive pin is an input under serial use, transmit pin is driven
  always_comb begin
    second_alt_active = '0;
    second_alt_out    = '0;
    second_alt_oe     = '0;
    second_alt_active[TBGP_RECEIVE_BIT]  = serial_interface_enable;
    second_alt_active[TBGP_TRANSMIT_BIT] = serial_interface_enable;
    second_alt_out[TBGP_TRANSMIT_BIT]    = serial_transmit_data;
    second_alt_oe[TBGP_TRANSMIT_BIT]     = 1'b1;
  end

  assign timer_channel_pin   = first_pin_level;
  assign serial_receive_data = second_pin_level[TBGP_RECEIVE_BIT];

  // ----------------------------------------------------------------------
  // pin cells and synchronisers
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < PINS; g++) begin : g_pin
    tbgp_pin_sync u_first_sync (
      .mclk      (mclk),
      .rst       (rst),
      .ce        (ce),
      .pin_async (first_port_pin_in[g]),
      .pin_level (first_pin_level[g])
    );

    tbgp_pin_sync u_second_sync (
      .mclk      (mclk),
      .rst       (rst),
      .ce        (ce),
      .pin_async (second_port_pin_in[g]),
      .pin_level (second_pin_level[g])
    );

    tbgp_pin_cell u_first_cell (
      .direction_bit (first_port_direction[g]),
      .latch_bit     (first_port_latch[g]),
      .alt_active    (first_alt_active[g]),
      .alt_out       (first_alt_out[g]),
      .alt_oe        (first_alt_oe[g]),
      .pin_level     (first_pin_level[g]),
      .next_pin_out  (next_first_pin_out[g]),
      .next_pin_oe   (next_first_pin_oe[g]),
      .read_bit      (first_read[g])
    );

    tbgp_pin_cell u_second_cell (
      .direction_bit (second_port_direction[g]),
      .latch_bit     (second_port_latch[g]),
      .alt_active    (second_alt_active[g]),
      .alt_out       (second_alt_out[g]),
      .alt_oe        (second_alt_oe[g]),
      .pin_level     (second_pin_level[g]),
      .next_pin_out  (next_second_pin_out[g]),
      .next_pin_oe   (next_second_pin_oe[g]),
      .read_bit      (second_read[g])
    );
  end

  // ----------------------------------------------------------------------
  // registered pin drive
  // ----------------------------------------------------------------------
  // registering costs one clock of latency but keeps pads glitch free
  always_ff @(posedge mclk) begin
    if (rst) begin
      first_port_pin_oe  <= TBGP_DIRECTION_RESET;
      first_port_pin_out <= TBGP_PIN_OUT_RESET;
    end else if (ce) begin
      first_port_pin_oe  <= next_first_pin_oe;
      first_port_pin_out <= next_first_pin_out;
    end
  end

  // latch loaded before the direction flip gives a clean first level
  always_ff @(posedge mclk) begin
    if (rst) begin
      second_port_pin_oe  <= TBGP_DIRECTION_RESET;
      second_port_pin_out <= TBGP_PIN_OUT_RESET;
    end else if (ce) begin
      second_port_pin_oe  <= next_second_pin_oe;
      second_port_pin_out <= next_second_pin_out;
    end
  end

endmodule // tbgp_ports
